// [core/meter_irq_device.sv]
`timescale 1ns/1ps
`include "meter_irq_regs.svh"
module meter_irq_device #(
  parameter int NV = 3,
  parameter int NC = 4,
  parameter int NA = 8,
  parameter int SW = 24
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   arst_n_in,
  // link to the host
  meter_link_if.dev_end               link,
  // processing cycle events
  input  wire logic                   cycle_start_in,
  input  wire logic                   cycle_done_in,
  input  wire logic                   real_neg_in,
  input  wire logic                   reactive_neg_in,
  // measurement samples
  input  wire logic [NV-1:0][SW-1:0]  volt_abs_in,
  input  wire logic [NV-1:0]          volt_zero_cross_in,
  input  wire logic [NC-1:0][SW-1:0]  curr_abs_in,
  input  wire logic [NA-1:0]          accum_carry_in,
  // supply monitor pin, asynchronous
  input  wire logic                   supply_fail_pin_in,
  // settings to the signal processor
  output logic                        fundamental_disable_out,
  output logic [15:0]                 sample_rate_out
);

  typedef struct packed {
    logic [15:0]   flags;
    logic [15:0]   enables;
    logic [SW-1:0] low_lvl;
    logic [SW-1:0] high_lvl;
    logic [SW-1:0] cur_lvl;
    logic [15:0]   zx_timo;
    logic [7:0]    mode_two;
    logic [15:0]   rate;
    logic          busy;
    logic          real_neg;
    logic          react_neg;
    logic          dir_valid;
    logic [1:0]    pf_sync;
    logic [15:0]   sum;
    logic          sum_valid;
    logic [15:0]   rdata;
    logic          irq_n;
  } dev_s;

  dev_s st;
  dev_s next_st;

  logic [NV-1:0] zx_missing;
  logic [NV-1:0] v_low;
  logic [NV-1:0] v_high;
  logic [NC-1:0] i_high;
  logic [15:0]   events;
  logic [15:0]   clear_mask;
  logic [15:0]   new_sum;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel detection

  genvar g;
  generate
    for (g = 0; g < NV; g++) begin : g_volt
      volt_channel_watch #(
        .SW (SW),
        .TW (16)
      ) u_watch (
        .clk_in         (clk_in),
        .arst_n_in      (arst_n_in),
        .cycle_start_in (cycle_start_in),
        .abs_level_in   (volt_abs_in[g]),
        .zero_cross_in  (volt_zero_cross_in[g]),
        .low_level_in   (st.low_lvl),
        .high_level_in  (st.high_lvl),
        .timeout_in     (st.zx_timo),
        .missing_out    (zx_missing[g]),
        .low_out        (v_low[g]),
        .high_out       (v_high[g])
      );
    end
    for (g = 0; g < NC; g++) begin : g_curr
      assign i_high[g] = curr_abs_in[g] > st.cur_lvl;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction

  function automatic logic [15:0] fold(input logic [SW-1:0] x);
    fold = 16'(x) + 16'(x >> 16);
  endfunction

  // checksum over the level, timeout, mode and rate registers; the enables are not included
  always_comb begin
    new_sum = fold(st.low_lvl) + fold(st.high_lvl) + fold(st.cur_lvl)
            + st.zx_timo + {8'h00, st.mode_two} + st.rate;
  end

  always_comb begin
    events                 = 16'h0000;
    events[`BIT_LATE]      = cycle_start_in && st.busy && !cycle_done_in;
    events[`BIT_DONE]      = cycle_done_in;
    events[`BIT_REACT_DIR] = cycle_done_in && st.dir_valid
                           && (reactive_neg_in != st.react_neg);
    events[`BIT_REAL_DIR]  = cycle_done_in && st.dir_valid
                           && (real_neg_in != st.real_neg);
    events[`BIT_NO_ZX]     = |zx_missing;
    events[`BIT_V_LOW]     = |v_low;
    events[`BIT_V_HIGH]    = |v_high;
    events[`BIT_I_HIGH]    = |i_high;
    events[`BIT_ACC_OVF]   = |accum_carry_in;
    events[`BIT_SUM_CHG]   = st.sum_valid && (new_sum != st.sum);
    events[`BIT_SUPPLY]    = st.pf_sync[1];
    clear_mask = (link.wr && hit(link.addr, `FLAGS_OFS)) ? link.wdata : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st           = st;
    next_st.pf_sync   = {st.pf_sync[0], supply_fail_pin_in};
    next_st.sum       = new_sum;
    next_st.sum_valid = 1'b1;
    // a new event beats a clear of the same bit
    next_st.flags = ((st.flags & ~clear_mask) | events) & `FLAG_IMPL_MASK;

    if (cycle_done_in) begin
      next_st.busy      = 1'b0;
      next_st.real_neg  = real_neg_in;
      next_st.react_neg = reactive_neg_in;
      next_st.dir_valid = 1'b1;
    end
    if (cycle_start_in) begin
      next_st.busy = 1'b1;
    end

    if (link.wr) begin
      if (hit(link.addr, `ENABLES_OFS)) begin
        next_st.enables = link.wdata & `FLAG_IMPL_MASK;
      end
      if (hit(link.addr, `MODE_TWO_OFS)) begin
        next_st.mode_two = link.wdata[7:0];
      end
      if (hit(link.addr, `LOW_LVL_OFS)) begin
        next_st.low_lvl = SW'(link.wdata);
      end
      if (hit(link.addr, `HIGH_LVL_OFS)) begin
        next_st.high_lvl = SW'(link.wdata);
      end
      if (hit(link.addr, `CUR_LVL_OFS)) begin
        next_st.cur_lvl = SW'(link.wdata);
      end
      if (hit(link.addr, `ZX_TIMO_OFS)) begin
        next_st.zx_timo = link.wdata;
      end
      if (hit(link.addr, `RATE_OFS)) begin
        next_st.rate = link.wdata;
      end
    end

    next_st.rdata = 16'h0000;
    if (link.rd) begin
      case (link.addr)
        `FLAGS_OFS:    next_st.rdata = st.flags;
        `ENABLES_OFS:  next_st.rdata = st.enables;
        `MODE_TWO_OFS: next_st.rdata = {8'h00, st.mode_two};
        `LOW_LVL_OFS:  next_st.rdata = st.low_lvl[15:0];
        `HIGH_LVL_OFS: next_st.rdata = st.high_lvl[15:0];
        `CUR_LVL_OFS:  next_st.rdata = st.cur_lvl[15:0];
        `ZX_TIMO_OFS:  next_st.rdata = st.zx_timo;
        `SUM_OFS:      next_st.rdata = st.sum;
        `RATE_OFS:     next_st.rdata = st.rate;
        default:       next_st.rdata = 16'h0000;
      endcase
    end

    // pin follows the flags in the same edge, no extra lag
    next_st.irq_n = ~|(next_st.flags & next_st.enables);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st          <= '0;
      st.flags    <= `FLAGS_RST;
      st.enables  <= `ENABLES_RST;
      st.mode_two <= `MODE_TWO_RST;
      st.rate     <= `RATE_RST;
      st.zx_timo  <= `ZX_TIMO_RST;
      st.low_lvl  <= '0;
      st.high_lvl <= '1;
      st.cur_lvl  <= '1;
      st.irq_n    <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign link.rdata              = st.rdata;
  assign link.irq_n              = st.irq_n;
  assign fundamental_disable_out = st.mode_two[`FUND_DIS_BIT];
  assign sample_rate_out         = st.rate;

endmodule

// [core/meter_irq_host.sv]
`timescale 1ns/1ps
`include "meter_irq_regs.svh"
module meter_irq_host (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // link to the device
  meter_link_if.host_end   link,
  // software register port
  input  wire logic [7:0]  sw_addr_in,
  input  wire logic [15:0] sw_wdata_in,
  input  wire logic        sw_wr_in,
  input  wire logic        sw_rd_in,
  output logic [15:0]      sw_rdata_out,
  // indications
  output logic             irq_out,
  output logic             save_state_out
);

  meter_irq_pkg::host_s st;
  meter_irq_pkg::host_s next_st;
  logic [15:0]          ev;
  logic [15:0]          clr;

  always_comb begin
    next_st    = st;
    ev         = 16'h0000;
    clr        = (sw_wr_in && sw_addr_in == `H_STATUS_OFS) ? sw_wdata_in : 16'h0000;
    next_st.wr = 1'b0;
    next_st.rd = 1'b0;

    case (st.state)
      meter_irq_pkg::S_IDLE: begin
        if (sw_wr_in && sw_addr_in == `H_DEV_EN_OFS) begin
          // forwarded at once; dropped while a service is running
          next_st.addr  = `ENABLES_OFS;
          next_st.wdata = sw_wdata_in;
          next_st.wr    = 1'b1;
        end else if (st.ctrl[`H_CTRL_AUTO] && !link.irq_n) begin
          next_st.addr  = `FLAGS_OFS;
          next_st.rd    = 1'b1;
          next_st.state = meter_irq_pkg::S_WAIT_F;
        end
      end
      meter_irq_pkg::S_WAIT_F: begin
        next_st.state = meter_irq_pkg::S_GET_F;
      end
      meter_irq_pkg::S_GET_F: begin
        // write back exactly what was seen so later events survive
        next_st.last_flags = link.rdata;
        next_st.addr       = `FLAGS_OFS;
        next_st.wdata      = link.rdata;
        next_st.wr         = 1'b1;
        next_st.pend_fix   = link.rdata[`BIT_LATE];
        next_st.pend_sum   = link.rdata[`BIT_SUM_CHG];
        ev[`H_ST_SUPPLY]   = link.rdata[`BIT_SUPPLY];
        ev[`H_ST_LATE]     = link.rdata[`BIT_LATE];
        ev[`H_ST_SERVICED] = 1'b1;
        next_st.state      = meter_irq_pkg::S_FIX;
      end
      meter_irq_pkg::S_FIX: begin
        next_st.state = meter_irq_pkg::S_RD_S;
        if (st.pend_fix) begin
          next_st.wr = 1'b1;
          if (st.ctrl[`H_CTRL_USE_RATE]) begin
            next_st.addr  = `RATE_OFS;
            next_st.wdata = st.rate;
          end else begin
            // opmode template lives in the upper control byte
            next_st.addr  = `MODE_TWO_OFS;
            next_st.wdata = {8'h00, st.ctrl[15:8]} | (16'h0001 << `FUND_DIS_BIT);
          end
        end
      end
      meter_irq_pkg::S_RD_S: begin
        if (st.pend_sum) begin
          next_st.addr  = `SUM_OFS;
          next_st.rd    = 1'b1;
          next_st.state = meter_irq_pkg::S_WAIT_S;
        end else begin
          next_st.state = meter_irq_pkg::S_IDLE;
        end
      end
      meter_irq_pkg::S_WAIT_S: begin
        next_st.state = meter_irq_pkg::S_GET_S;
      end
      meter_irq_pkg::S_GET_S: begin
        next_st.last_sum = link.rdata;
        ev[`H_ST_SUM]    = 1'b1;
        next_st.state    = meter_irq_pkg::S_IDLE;
      end
      default: begin
        next_st.state = meter_irq_pkg::S_IDLE;
      end
    endcase

    // set wins over a software clear
    next_st.status = (st.status & ~clr) | ev;
    if (sw_wr_in) begin
      case (sw_addr_in)
        `H_MASK_OFS: next_st.mask = sw_wdata_in;
        `H_CTRL_OFS: next_st.ctrl = sw_wdata_in;
        `H_RATE_OFS: next_st.rate = sw_wdata_in;
        default:     next_st.mask = next_st.mask;
      endcase
    end
    next_st.sw_rdata = 16'h0000;
    if (sw_rd_in) begin
      case (sw_addr_in)
        `H_STATUS_OFS: next_st.sw_rdata = st.status;
        `H_MASK_OFS:   next_st.sw_rdata = st.mask;
        `H_FLAGS_OFS:  next_st.sw_rdata = st.last_flags;
        `H_SUM_OFS:    next_st.sw_rdata = st.last_sum;
        `H_CTRL_OFS:   next_st.sw_rdata = st.ctrl;
        `H_RATE_OFS:   next_st.sw_rdata = st.rate;
        default:       next_st.sw_rdata = 16'h0000;
      endcase
    end
    next_st.irq        = |(next_st.status & next_st.mask);
    next_st.save_state = next_st.status[`H_ST_SUPPLY];
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st       <= '0;
      st.state <= meter_irq_pkg::S_IDLE;
      st.ctrl  <= `H_CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  assign link.addr      = st.addr;
  assign link.wdata     = st.wdata;
  assign link.wr        = st.wr;
  assign link.rd        = st.rd;
  assign sw_rdata_out   = st.sw_rdata;
  assign irq_out        = st.irq;
  assign save_state_out = st.save_state;

endmodule

// [core/volt_channel_watch.sv]
`timescale 1ns/1ps
`include "meter_irq_regs.svh"
module volt_channel_watch #(
  parameter int SW = 24,
  parameter int TW = 16
) (
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          arst_n_in,
  // cycle timing and sample
  input  wire logic          cycle_start_in,
  input  wire logic [SW-1:0] abs_level_in,
  input  wire logic          zero_cross_in,
  // thresholds
  input  wire logic [SW-1:0] low_level_in,
  input  wire logic [SW-1:0] high_level_in,
  input  wire logic [TW-1:0] timeout_in,
  // one-cycle events on missing_out and low_out; high_out follows the level
  output logic               missing_out,
  output logic               low_out,
  output logic               high_out
);

  typedef struct packed {
    logic [TW-1:0] cnt;
    logic          exceeded;
    logic          armed;
    logic          missing;
    logic          low;
    logic          high;
  } watch_s;

  watch_s st;
  watch_s next_st;

  always_comb begin
    next_st         = st;
    next_st.missing = 1'b0;
    next_st.low     = 1'b0;
    next_st.high    = abs_level_in > high_level_in;
    if (zero_cross_in) begin
      next_st.cnt = '0;
    end else if (cycle_start_in && st.cnt != timeout_in) begin
      // saturates so one outage reports once; timeout of zero disables
      next_st.cnt     = st.cnt + 1'b1;
      next_st.missing = (st.cnt + 1'b1) == timeout_in;
    end
    if (cycle_start_in) begin
      // first partial cycle after reset is not judged
      next_st.low      = st.armed && !st.exceeded;
      next_st.exceeded = abs_level_in > low_level_in;
      next_st.armed    = 1'b1;
    end else if (abs_level_in > low_level_in) begin
      next_st.exceeded = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign missing_out = st.missing;
  assign low_out     = st.low;
  assign high_out    = st.high;

endmodule

// [dv/meter_interrupt_flags_tb.sv]
`timescale 1ns/1ps
`include "meter_irq_regs.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
  $display("FAIL t=%0t got %h exp %h", $time, (got), (exp)); end end
module meter_interrupt_flags_tb;
  logic             clk_in             = 1'b0;
  logic             arst_n_in          = 1'b0;
  logic             cycle_start_in     = 1'b0;
  logic             cycle_done_in      = 1'b0;
  logic             real_neg_in        = 1'b0;
  logic             reactive_neg_in    = 1'b0;
  logic [2:0][23:0] volt_abs_in        = {3{24'h000050}};
  logic [2:0]       volt_zero_cross_in = 3'b000;
  logic [3:0][23:0] curr_abs_in        = {4{24'h000000}};
  logic [7:0]       accum_carry_in     = 8'h00;
  logic             supply_fail_pin_in = 1'b0;
  logic [7:0]       sw_addr_in         = 8'h00;
  logic [15:0]      sw_wdata_in        = 16'h0000;
  logic             sw_wr_in           = 1'b0;
  logic             sw_rd_in           = 1'b0;
  logic [15:0]      sw_rdata_out;
  logic             irq_out;
  logic             save_state_out;
  logic             fd_b;
  logic [15:0]      rate_b;
  logic             fd_a;
  logic [15:0]      rate_a;
  int               failures           = 0;
  int               compares           = 0;
  int               cycles             = 0;
  logic [15:0]      exp_t [7]          = '{16'h4000, 16'h0004, 16'h0100, 16'h0200,
                                           16'h0001, 16'h5000, 16'h6000};
  meter_link_if link_a ();
  // second link: the bench plays a host that may leave flags uncleared
  meter_link_if link_b ();
  always #12.5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////
  meter_irq_host u_meter_irq_host (
    .clk_in, .arst_n_in, .link(link_a.host_end), .sw_addr_in, .sw_wdata_in, .sw_wr_in,
    .sw_rd_in, .sw_rdata_out, .irq_out, .save_state_out);
  meter_irq_device u_meter_irq_device (
    .clk_in, .arst_n_in, .link(link_a.dev_end), .cycle_start_in, .cycle_done_in,
    .real_neg_in, .reactive_neg_in, .volt_abs_in, .volt_zero_cross_in, .curr_abs_in,
    .accum_carry_in, .supply_fail_pin_in, .fundamental_disable_out(fd_a),
    .sample_rate_out(rate_a));
  meter_irq_device u_meter_irq_device_b (
    .clk_in, .arst_n_in, .link(link_b.dev_end), .cycle_start_in, .cycle_done_in,
    .real_neg_in, .reactive_neg_in, .volt_abs_in, .volt_zero_cross_in, .curr_abs_in,
    .accum_carry_in, .supply_fail_pin_in, .fundamental_disable_out(fd_b),
    .sample_rate_out(rate_b));
  meter_link_asserts u_meter_link_asserts (
    .clk_in, .arst_n_in, .addr(link_a.addr), .wdata(link_a.wdata), .wr(link_a.wr),
    .rd(link_a.rd), .rdata(link_a.rdata), .irq_n(link_a.irq_n));
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      conclude();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wreg(input bit host, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    if (host) begin
      sw_addr_in  <= a;
      sw_wdata_in <= d;
      sw_wr_in    <= 1'b1;
    end else begin
      link_b.addr  <= a;
      link_b.wdata <= d;
      link_b.wr    <= 1'b1;
    end
    @(posedge clk_in);
    sw_wr_in  <= 1'b0;
    link_b.wr <= 1'b0;
  endtask
  task automatic rchk(input bit host, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_in);
    if (host) begin
      sw_addr_in <= a;
      sw_rd_in   <= 1'b1;
    end else begin
      link_b.addr <= a;
      link_b.rd   <= 1'b1;
    end
    @(posedge clk_in);
    sw_rd_in  <= 1'b0;
    link_b.rd <= 1'b0;
    #1 `CHK(host ? sw_rdata_out : link_b.rdata, e)
  endtask
  task automatic fire(input int k);
    @(posedge clk_in);
    case (k)
      0: cycle_done_in <= 1'b1;
      1: accum_carry_in[5] <= 1'b1;
      2: curr_abs_in[3] <= 24'h000101;
      3: volt_abs_in[1] <= 24'h000101;
      4: supply_fail_pin_in <= 1'b1;
      5: begin
        real_neg_in   <= 1'b1;
        cycle_done_in <= 1'b1;
      end
      default: begin
        reactive_neg_in <= 1'b1;
        cycle_done_in   <= 1'b1;
      end
    endcase
    @(posedge clk_in);
    cycle_done_in      <= 1'b0;
    accum_carry_in     <= 8'h00;
    curr_abs_in[3]     <= 24'h000000;
    volt_abs_in[1]     <= 24'h000050;
    supply_fail_pin_in <= 1'b0;
  endtask
  task automatic strobe_start(input logic [2:0] z);
    @(posedge clk_in);
    cycle_start_in     <= 1'b1;
    volt_zero_cross_in <= z;
    @(posedge clk_in);
    cycle_start_in     <= 1'b0;
    volt_zero_cross_in <= 3'b000;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic reset_and_host();
    `CHK(link_b.irq_n, 1'b1)
    rchk(0, `FLAGS_OFS, `FLAGS_RST);
    rchk(0, `ENABLES_OFS, `ENABLES_RST);
    rchk(0, 8'h7E, 16'h0000);
    rchk(1, `H_CTRL_OFS, `H_CTRL_RST);
    wreg(1, `H_MASK_OFS, 16'h000F);
    rchk(1, `H_MASK_OFS, 16'h000F);
    rchk(1, 8'h3C, 16'h0000);
    `CHK({irq_out, save_state_out}, 2'b00)
  endtask
  task automatic event_table();
    wreg(0, `ENABLES_OFS, 16'hFFFF);
    rchk(0, `ENABLES_OFS, `FLAG_IMPL_MASK);
    wreg(0, `FLAGS_OFS, 16'hFFFF);
    wreg(0, `HIGH_LVL_OFS, 16'h0100);
    wreg(0, `CUR_LVL_OFS, 16'h0100);
    tick(3);
    rchk(0, `FLAGS_OFS, 16'h0002);
    wreg(0, `FLAGS_OFS, 16'h0002);
    for (int k = 0; k < 7; k++) begin
      fire(k);
      tick(4);
      `CHK(link_b.irq_n, 1'b0)
      rchk(0, `FLAGS_OFS, exp_t[k]);
      wreg(0, `FLAGS_OFS, exp_t[k]);
      tick(1);
      `CHK(link_b.irq_n, 1'b1)
    end
  endtask
  task automatic overrun_and_zero_cross();
    @(posedge clk_in);
    volt_abs_in[2] <= 24'h000000;
    strobe_start(3'b011);
    tick(3);
    strobe_start(3'b011);
    volt_abs_in[2] <= 24'h000050;
    tick(4);
    rchk(0, `FLAGS_OFS, 16'h8400);
    wreg(0, `FLAGS_OFS, 16'h8400);
    wreg(0, `ZX_TIMO_OFS, 16'h0002);
    for (int i = 0; i < 3; i++) begin
      fire(0);
      strobe_start(i == 0 ? 3'b111 : 3'b011);
    end
    fire(0);
    tick(4);
    rchk(0, `FLAGS_OFS, 16'h4802);
    wreg(0, `FLAGS_OFS, 16'h4802);
    rchk(0, `FLAGS_OFS, 16'h0000);
  endtask
  task automatic mask_and_settings();
    wreg(0, `ENABLES_OFS, 16'h0001);
    fire(1);
    tick(4);
    `CHK(link_b.irq_n, 1'b1)
    wreg(0, `ENABLES_OFS, 16'h0004);
    // left uncleared: the request must hold, not fade
    tick(8);
    `CHK(link_b.irq_n, 1'b0)
    wreg(0, `FLAGS_OFS, 16'h0004);
    tick(1);
    `CHK(link_b.irq_n, 1'b1)
    wreg(0, `MODE_TWO_OFS, 16'h0010);
    wreg(0, `RATE_OFS, 16'h1234);
    tick(1);
    `CHK({fd_b, rate_b}, 17'h11234)
    rchk(0, `RATE_OFS, 16'h1234);
  endtask
  task automatic host_service();
    wreg(1, `H_RATE_OFS, 16'h0040);
    wreg(1, `H_CTRL_OFS, 16'h0003);
    // overrun and supply flags from earlier scenarios still wait on this side
    wreg(1, `H_DEV_EN_OFS, 16'h8002);
    tick(40);
    `CHK({fd_a, rate_a}, 17'h00040)
    rchk(1, `H_STATUS_OFS, 16'h000F);
    rchk(1, `H_FLAGS_OFS, 16'h0002);
    // reset levels fold to 0x01FC, plus the new rate
    rchk(1, `H_SUM_OFS, 16'h023C);
    `CHK({irq_out, save_state_out}, 2'b11)
    wreg(1, `H_STATUS_OFS, 16'h000F);
    tick(1);
    `CHK({irq_out, save_state_out}, 2'b00)
  endtask
  initial begin
    link_b.addr  = 8'h00;
    link_b.wdata = 16'h0000;
    link_b.wr    = 1'b0;
    link_b.rd    = 1'b0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    tick(0);
    reset_and_host();
    event_table();
    overrun_and_zero_cross();
    mask_and_settings();
    host_service();
    conclude();
  end
endmodule

// [dv/meter_link_asserts.sv]
`timescale 1ns/1ps
`include "meter_irq_regs.svh"
module meter_link_asserts (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  // link signals
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        irq_n
);
  // shadow of the enables; reserved bits dropped so readback compares stay exact
  logic [15:0] en_copy;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_copy <= 16'h0000;
    end else if (wr && addr == `ENABLES_OFS) begin
      en_copy <= wdata & `FLAG_IMPL_MASK;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence flags_read;
    rd && addr == `FLAGS_OFS;
  endsequence
  sequence flags_clear;
    wr && addr == `FLAGS_OFS;
  endsequence
  strobes_excl_a: assert property (!(wr && rd)) else $error("both strobes high");
  rdata_idle_a: assert property (!rd |=> rdata == 16'h0000) else $error("stray read data");
  unmapped_zero_a: assert property (rd && !(addr inside {`MODE_TWO_OFS, `FLAGS_OFS,
    `ENABLES_OFS, `LOW_LVL_OFS, `HIGH_LVL_OFS, `CUR_LVL_OFS, `ZX_TIMO_OFS, `SUM_OFS,
    `RATE_OFS}) |=> rdata == 16'h0000) else $error("unmapped read not zero");
  flag_rsvd_a: assert property (flags_read |=> rdata[7:3] == 5'h00)
    else $error("reserved flag bits set");
  en_readback_a: assert property (rd && addr == `ENABLES_OFS |=>
    (rdata & `FLAG_IMPL_MASK) == en_copy) else $error("enables readback wrong");
  irq_quiet_a: assert property (en_copy == 16'h0000 && $past(en_copy) == 16'h0000
    |-> irq_n) else $error("request with nothing enabled");
  irq_cause_a: assert property (rd && addr == `FLAGS_OFS && !irq_n
    |=> (rdata & en_copy) != 16'h0000) else $error("request without enabled flag");
  service_walk_a: assert property (flags_read |-> ##2 flags_clear)
    else $error("read flags not cleared");
endmodule

// [shared/meter_irq_pkg.sv]
package meter_irq_pkg;

  typedef enum logic [6:0] {
    S_IDLE   = 7'h01,
    S_WAIT_F = 7'h02,
    S_GET_F  = 7'h04,
    S_FIX    = 7'h08,
    S_RD_S   = 7'h10,
    S_WAIT_S = 7'h20,
    S_GET_S  = 7'h40
  } host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [15:0] status;
    logic [15:0] mask;
    logic [15:0] last_flags;
    logic [15:0] last_sum;
    logic [15:0] ctrl;
    logic [15:0] rate;
    logic        pend_fix;
    logic        pend_sum;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] sw_rdata;
    logic        irq;
    logic        save_state;
  } host_s;

endpackage

// [shared/meter_irq_regs.svh]
`ifndef METER_IRQ_REGS_SVH
`define METER_IRQ_REGS_SVH

// device registers on the link
`define MODE_TWO_OFS    8'h03
`define FLAGS_OFS       8'h04
`define ENABLES_OFS     8'h06
`define LOW_LVL_OFS     8'h10
`define HIGH_LVL_OFS    8'h12
`define CUR_LVL_OFS     8'h14
`define ZX_TIMO_OFS     8'h16
`define SUM_OFS         8'h18
`define RATE_OFS        8'h20

// flag bit positions
`define BIT_LATE        15
`define BIT_DONE        14
`define BIT_REACT_DIR   13
`define BIT_REAL_DIR    12
`define BIT_NO_ZX       11
`define BIT_V_LOW       10
`define BIT_V_HIGH      9
`define BIT_I_HIGH      8
`define BIT_ACC_OVF     2
`define BIT_SUM_CHG     1
`define BIT_SUPPLY      0
`define FLAG_IMPL_MASK  16'hFF07
`define FUND_DIS_BIT    4

// reset values
`define FLAGS_RST       16'h0000
`define ENABLES_RST     16'h0000
`define MODE_TWO_RST    8'h00
`define RATE_RST        16'h0000
`define ZX_TIMO_RST     16'h0000

// host-side software registers
`define H_STATUS_OFS    8'h00
`define H_MASK_OFS      8'h04
`define H_FLAGS_OFS     8'h08
`define H_SUM_OFS       8'h0C
`define H_CTRL_OFS      8'h10
`define H_RATE_OFS      8'h14
`define H_DEV_EN_OFS    8'h18
`define H_ST_SUPPLY     0
`define H_ST_SUM        1
`define H_ST_LATE       2
`define H_ST_SERVICED   3
`define H_CTRL_AUTO     0
`define H_CTRL_USE_RATE 1
`define H_CTRL_RST      16'h0001

`endif

// [shared/meter_link_if.sv]
`timescale 1ns/1ps
interface meter_link_if;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        irq_n;

  modport dev_end  (input addr, input wdata, input wr, input rd, output rdata, output irq_n);
  modport host_end (output addr, output wdata, output wr, output rd, input rdata, input irq_n);
endinterface
